//--- core/uart_ctrl.sv
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// Overview of operation
// - trigger code maps to 1,4,8,14 bytes
// - four priority levels, highest pending reported
// - reported source held until serviced
// - read clears only reported source
// - line status: level 1, code 0110
// - data available: level 2, code 0100
// - receive timeout: level 2, code 1100
// - holding empty: level 3, code 0010
// - modem change: level 4, code 0000
// - bits 7:6 show FIFOs enabled
// - bit 0 low while interrupt pending
// - format bit 7 opens divisor access
// - format bit 6 holds transmit low
// - format bit 3 enables parity
// - format bit 4 selects even parity
// - forced parity is inverse of bit 4
// - bit 2 gives 1.5 or 2 stops
// - bits 1:0 give 5 to 8 bits
// - setup bit 0 enables both FIFOs
module uart_ctrl (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input uart_ctrl_pkg::irq_events_t irq_events,
    input wire logic [4:0] rx_count,
    input wire logic tx_serial_in,
    input wire logic [7:0] tx_char,
    input wire logic [7:0] rx_char,
    input wire logic rx_parity_in,
    input wire logic rx_char_valid,
    output logic tx_line,
    output logic tx_parity,
    output logic rx_parity_err,
    output logic rx_data_available,
    output logic irq,
    output uart_ctrl_pkg::line_cfg_t line_cfg
);

    uart_ctrl_pkg::state_t r_reg;
    uart_ctrl_pkg::state_t r_next;
    logic [uart_ctrl_pkg::NSRC-1:0] ev;
    logic [uart_ctrl_pkg::NSRC-1:0] clr;
    logic access;
    logic id_read;
    logic hit;

    // first set bit wins, index order is priority order
    function automatic logic [2:0] prio_pick(input logic [uart_ctrl_pkg::NSRC-1:0] p);
        logic [2:0] s;
        s = uart_ctrl_pkg::SRC_MODEM;
        for (int i = uart_ctrl_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (p[i])
            begin
                s = 3'(i);
            end
        end
        return s;
    endfunction

    function automatic logic [3:0] id_code(input logic [2:0] src);
        logic [3:0] c;
        case (src)
            uart_ctrl_pkg::SRC_LINE: c = uart_ctrl_pkg::ID_LINE;
            uart_ctrl_pkg::SRC_RX_DATA: c = uart_ctrl_pkg::ID_RX_DATA;
            uart_ctrl_pkg::SRC_TIMEOUT: c = uart_ctrl_pkg::ID_TIMEOUT;
            uart_ctrl_pkg::SRC_THR_EMPTY: c = uart_ctrl_pkg::ID_THR_EMPTY;
            default: c = uart_ctrl_pkg::ID_MODEM;
        endcase
        return c;
    endfunction

    // expected parity bit for a character under the given format
    function automatic logic parity_calc(input logic [7:0] data, input logic [7:0] lf);
        logic [7:0] mask;
        logic x;
        case (lf[1:0])
            2'h0: mask = 8'h1F;
            2'h1: mask = 8'h3F;
            2'h2: mask = 8'h7F;
            default: mask = 8'hFF;
        endcase
        x = ^(data & mask);
        if (lf[uart_ctrl_pkg::LF_FORCE])
        begin
            parity_calc = ~lf[uart_ctrl_pkg::LF_EVEN];
        end
        else
        begin
            parity_calc = lf[uart_ctrl_pkg::LF_EVEN] ? x : ~x;
        end
    endfunction

    // format decode straight from the stored registers
    always_comb
    begin
        line_cfg.divisor_access = r_reg.line_format[uart_ctrl_pkg::LF_DIVISOR];
        line_cfg.break_on = r_reg.line_format[uart_ctrl_pkg::LF_BREAK];
        line_cfg.parity_en = r_reg.line_format[uart_ctrl_pkg::LF_PAR_EN];
        line_cfg.parity_even = r_reg.line_format[uart_ctrl_pkg::LF_EVEN];
        line_cfg.parity_forced = r_reg.line_format[uart_ctrl_pkg::LF_FORCE];
        line_cfg.word_bits = uart_ctrl_pkg::WORD_MIN + {2'b00, r_reg.line_format[1:0]};
        if (!r_reg.line_format[uart_ctrl_pkg::LF_STOP])
        begin
            line_cfg.stop_halves = uart_ctrl_pkg::STOP_ONE;
        end
        else if (r_reg.line_format[1:0] == 2'h0)
        begin
            line_cfg.stop_halves = uart_ctrl_pkg::STOP_ONE_HALF;
        end
        else
        begin
            line_cfg.stop_halves = uart_ctrl_pkg::STOP_TWO;
        end
        line_cfg.fifo_en = r_reg.fifo_setup[uart_ctrl_pkg::FS_ENABLE];
        case (r_reg.fifo_setup[uart_ctrl_pkg::FS_TRIG_LO +: 2])
            2'h0: line_cfg.rx_threshold = uart_ctrl_pkg::TRIG_1;
            2'h1: line_cfg.rx_threshold = uart_ctrl_pkg::TRIG_4;
            2'h2: line_cfg.rx_threshold = uart_ctrl_pkg::TRIG_8;
            default: line_cfg.rx_threshold = uart_ctrl_pkg::TRIG_14;
        endcase
    end

    // without FIFOs one byte is enough to raise data available
    assign hit = line_cfg.fifo_en ? (rx_count >= line_cfg.rx_threshold) : (rx_count != 5'h00);
    assign access = wb_cyc_i && wb_stb_i && (r_reg.bus == uart_ctrl_pkg::BUS_IDLE);
    assign id_read = access && !wb_we_i && (wb_adr_i == uart_ctrl_pkg::OFF_IDENT);

    // source events; the timeout only exists with FIFOs on
    always_comb
    begin
        ev = '0;
        ev[uart_ctrl_pkg::SRC_LINE] = irq_events.line_status;
        ev[uart_ctrl_pkg::SRC_RX_DATA] = hit && !r_reg.rx_hit;
        ev[uart_ctrl_pkg::SRC_TIMEOUT] = irq_events.rx_timeout && line_cfg.fifo_en;
        ev[uart_ctrl_pkg::SRC_THR_EMPTY] = irq_events.thr_empty;
        ev[uart_ctrl_pkg::SRC_MODEM] = irq_events.modem_change;
        clr = '0;
        if (id_read && r_reg.cur_valid)
        begin
            clr[r_reg.cur_src] = 1'b1;
        end
    end

    // next state of the whole block
    always_comb
    begin
        r_next = r_reg;
        r_next.rx_hit = hit;
        // set wins over the read clear in the same cycle
        r_next.pending = (r_reg.pending & ~clr) | ev;
        if (id_read)
        begin
            r_next.cur_valid = 1'b0;
        end
        else if (!r_reg.cur_valid && (|r_reg.pending))
        begin
            // latch once, so a later source cannot replace the report
            r_next.cur_valid = 1'b1;
            r_next.cur_src = prio_pick(r_reg.pending);
        end
        // break overrides the serializer until software drops it
        r_next.tx_out = line_cfg.break_on ? 1'b0 : tx_serial_in;
        r_next.tx_parity = line_cfg.parity_en ? parity_calc(tx_char, r_reg.line_format) : 1'b0;
        if (rx_char_valid)
        begin
            r_next.rx_parity_err = line_cfg.parity_en &&
                (rx_parity_in != parity_calc(rx_char, r_reg.line_format));
        end
        case (r_reg.bus)
            uart_ctrl_pkg::BUS_IDLE:
            begin
                r_next.ack = 1'b0;
                if (access)
                begin
                    r_next.bus = uart_ctrl_pkg::BUS_ACK;
                    r_next.ack = 1'b1;
                    r_next.rdat = 32'h0000_0000;
                    if (wb_we_i && wb_sel_i[0])
                    begin
                        case (wb_adr_i)
                            uart_ctrl_pkg::OFF_LINE_FORMAT:
                                r_next.line_format = wb_dat_i[7:0];
                            uart_ctrl_pkg::OFF_FIFO_SETUP:
                            begin
                                // trigger only takes when enable is written as one
                                if (wb_dat_i[uart_ctrl_pkg::FS_ENABLE])
                                begin
                                    r_next.fifo_setup = wb_dat_i[7:0] &
                                        uart_ctrl_pkg::FIFO_SETUP_KEEP;
                                end
                                else
                                begin
                                    r_next.fifo_setup = uart_ctrl_pkg::FIFO_SETUP_RST;
                                end
                            end
                            default:
                                r_next.line_format = r_reg.line_format;
                        endcase
                    end
                    else if (!wb_we_i)
                    begin
                        case (wb_adr_i)
                            uart_ctrl_pkg::OFF_FIFO_SETUP:
                                r_next.rdat[7:0] = r_reg.fifo_setup;
                            uart_ctrl_pkg::OFF_IDENT:
                            begin
                                r_next.rdat[7:6] = {2{line_cfg.fifo_en}};
                                r_next.rdat[3:0] = r_reg.cur_valid ?
                                    id_code(r_reg.cur_src) : uart_ctrl_pkg::ID_NONE;
                            end
                            uart_ctrl_pkg::OFF_LINE_FORMAT:
                                r_next.rdat[7:0] = r_reg.line_format;
                            uart_ctrl_pkg::OFF_FORMAT_STATUS:
                                r_next.rdat[17:0] = {r_reg.rx_parity_err, r_reg.rx_hit,
                                    1'b0, line_cfg.stop_halves, line_cfg.word_bits,
                                    3'h0, line_cfg.rx_threshold};
                            default:
                                r_next.rdat = 32'h0000_0000;
                        endcase
                    end
                end
            end
            uart_ctrl_pkg::BUS_ACK:
            begin
                // ack drops the cycle after it was given
                r_next.ack = 1'b0;
                r_next.bus = uart_ctrl_pkg::BUS_IDLE;
            end
            default:
            begin
                r_next.ack = 1'b0;
                r_next.bus = uart_ctrl_pkg::BUS_IDLE;
            end
        endcase
    end

    // single register bank for all state
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            r_reg.bus <= uart_ctrl_pkg::BUS_IDLE;
            r_reg.ack <= 1'b0;
            r_reg.rdat <= 32'h0000_0000;
            r_reg.fifo_setup <= uart_ctrl_pkg::FIFO_SETUP_RST;
            r_reg.line_format <= uart_ctrl_pkg::LINE_FORMAT_RST;
            r_reg.pending <= '0;
            r_reg.cur_valid <= 1'b0;
            r_reg.cur_src <= 3'h0;
            r_reg.rx_hit <= 1'b0;
            r_reg.tx_out <= 1'b1;
            r_reg.tx_parity <= 1'b0;
            r_reg.rx_parity_err <= 1'b0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // outputs all come from flops, except line_cfg, which is decoded from them
    assign wb_dat_o = r_reg.rdat;
    assign wb_ack_o = r_reg.ack;
    assign tx_line = r_reg.tx_out;
    assign tx_parity = r_reg.tx_parity;
    assign rx_parity_err = r_reg.rx_parity_err;
    assign rx_data_available = r_reg.rx_hit;
    assign irq = r_reg.cur_valid;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence seq_ident_read;
        id_read;
    endsequence

    sequence seq_report_taken;
        !r_reg.cur_valid && (|r_reg.pending) && !id_read;
    endsequence

    sequence seq_setup_write;
        access && wb_we_i && wb_sel_i[0] && wb_adr_i == uart_ctrl_pkg::OFF_FIFO_SETUP;
    endsequence

    chk_trigger_decode: assert property (
        line_cfg.fifo_en |-> line_cfg.rx_threshold ==
            ((r_reg.fifo_setup[7:6] == 2'h0) ? 5'h01 : (r_reg.fifo_setup[7:6] == 2'h1) ? 5'h04 :
            (r_reg.fifo_setup[7:6] == 2'h2) ? 5'h08 : 5'h0E))
        else $error("receive trigger threshold wrong");

    chk_prio_top: assert property (
        seq_report_taken ##0 r_reg.pending[0] |=> r_reg.cur_valid && r_reg.cur_src == 3'h0)
        else $error("line status not chosen first");

    chk_report_hold: assert property (
        r_reg.cur_valid && !id_read |=> r_reg.cur_valid && $stable(r_reg.cur_src))
        else $error("reported source changed before service");

    chk_read_clear: assert property (
        seq_ident_read ##0 r_reg.cur_valid && !ev[r_reg.cur_src] |=>
            !r_reg.cur_valid && !r_reg.pending[$past(r_reg.cur_src)])
        else $error("read did not clear reported source");

    chk_line_code: assert property (
        seq_ident_read ##0 r_reg.cur_valid && r_reg.cur_src == 3'h0 |=> wb_dat_o[3:0] == 4'h6)
        else $error("line status code wrong");

    chk_ident_code: assert property (
        seq_ident_read ##0 r_reg.cur_valid |=> wb_dat_o[3:0] == id_code($past(r_reg.cur_src)))
        else $error("identification code wrong");

    chk_fifo_bits: assert property (
        seq_ident_read |=> wb_dat_o[7:6] == {2{$past(line_cfg.fifo_en)}} && wb_dat_o[5:4] == 2'h0)
        else $error("fifo enabled bits wrong");

    chk_none_bit: assert property (
        seq_ident_read ##0 !r_reg.cur_valid |=> wb_dat_o[3:0] == 4'h1)
        else $error("idle code wrong");

    chk_break_low: assert property (
        line_cfg.break_on |=> !tx_line)
        else $error("break did not hold line low");

    chk_parity_off: assert property (
        rx_char_valid && !line_cfg.parity_en |=> !rx_parity_err)
        else $error("parity error without parity");

    chk_irq_follow: assert property (
        seq_report_taken |=> irq ##0 (r_reg.cur_valid [*1]))
        else $error("interrupt output not raised");

    chk_wb_ack: assert property (
        access |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge timing wrong");

    chk_irq_drop: assert property (
        seq_ident_read |=> !irq)
        else $error("interrupt output still high after read");

    chk_rx_data_code: assert property (
        seq_ident_read ##0 r_reg.cur_valid && r_reg.cur_src == uart_ctrl_pkg::SRC_RX_DATA
            |=> wb_dat_o[3:0] == 4'h4)
        else $error("data available code wrong");

    chk_setup_off: assert property (
        seq_setup_write ##0 !wb_dat_i[uart_ctrl_pkg::FS_ENABLE] |=> !line_cfg.fifo_en)
        else $error("fifo enable not cleared by setup write");

    chk_setup_on: assert property (
        seq_setup_write ##0 wb_dat_i[uart_ctrl_pkg::FS_ENABLE] |=> line_cfg.fifo_en)
        else $error("fifo enable not set by setup write");

    chk_timeout_gate: assert property (
        !line_cfg.fifo_en && !r_reg.pending[uart_ctrl_pkg::SRC_TIMEOUT] |=>
            !r_reg.pending[uart_ctrl_pkg::SRC_TIMEOUT])
        else $error("timeout pending with FIFOs off");

    chk_even_parity: assert property (
        line_cfg.parity_en && !line_cfg.parity_forced && line_cfg.parity_even &&
            r_reg.line_format[1:0] == 2'h3 |=> tx_parity == ^$past(tx_char))
        else $error("even parity bit wrong");

    chk_forced_parity: assert property (
        line_cfg.parity_en && line_cfg.parity_forced |=>
            tx_parity == !$past(line_cfg.parity_even))
        else $error("forced parity bit wrong");

    chk_break_release: assert property (
        !line_cfg.break_on |=> tx_line == $past(tx_serial_in))
        else $error("line not following serializer");

endmodule

//--- core/uart_ctrl_pkg.sv
package uart_ctrl_pkg;
    // register byte offsets, one aligned word each
    localparam logic [3:0] OFF_FIFO_SETUP = 4'h0;
    localparam logic [3:0] OFF_IDENT = 4'h4;
    localparam logic [3:0] OFF_LINE_FORMAT = 4'h8;
    localparam logic [3:0] OFF_FORMAT_STATUS = 4'hC;

    // line_format_control fields
    localparam int LF_DIVISOR = 7;
    localparam int LF_BREAK = 6;
    localparam int LF_FORCE = 5;
    localparam int LF_EVEN = 4;
    localparam int LF_PAR_EN = 3;
    localparam int LF_STOP = 2;
    localparam logic [7:0] LINE_FORMAT_RST = 8'h00;

    // fifo_setup_control fields
    localparam int FS_ENABLE = 0;
    localparam int FS_TRIG_LO = 6;
    localparam logic [7:0] FIFO_SETUP_RST = 8'h00;
    localparam logic [7:0] FIFO_SETUP_KEEP = 8'hC1;

    // receive trigger thresholds in bytes
    localparam logic [4:0] TRIG_1 = 5'h01;
    localparam logic [4:0] TRIG_4 = 5'h04;
    localparam logic [4:0] TRIG_8 = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0E;

    // identification codes, bits 3:0
    localparam logic [3:0] ID_LINE = 4'h6;
    localparam logic [3:0] ID_RX_DATA = 4'h4;
    localparam logic [3:0] ID_TIMEOUT = 4'hC;
    localparam logic [3:0] ID_THR_EMPTY = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;
    localparam logic [3:0] ID_NONE = 4'h1;

    // interrupt sources, index order is priority order
    localparam int NSRC = 5;
    localparam logic [2:0] SRC_LINE = 3'h0;
    localparam logic [2:0] SRC_RX_DATA = 3'h1;
    localparam logic [2:0] SRC_TIMEOUT = 3'h2;
    localparam logic [2:0] SRC_THR_EMPTY = 3'h3;
    localparam logic [2:0] SRC_MODEM = 3'h4;

    // stop length in half bit times
    localparam logic [2:0] STOP_ONE = 3'h2;
    localparam logic [2:0] STOP_ONE_HALF = 3'h3;
    localparam logic [2:0] STOP_TWO = 3'h4;
    localparam logic [3:0] WORD_MIN = 4'h5;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic line_status;
        logic rx_timeout;
        logic thr_empty;
        logic modem_change;
    } irq_events_t;

    typedef struct packed {
        logic divisor_access;
        logic break_on;
        logic parity_en;
        logic parity_even;
        logic parity_forced;
        logic [3:0] word_bits;
        logic [2:0] stop_halves;
        logic fifo_en;
        logic [4:0] rx_threshold;
    } line_cfg_t;

    typedef struct packed {
        bus_state_t bus;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] fifo_setup;
        logic [7:0] line_format;
        logic [NSRC-1:0] pending;
        logic cur_valid;
        logic [2:0] cur_src;
        logic rx_hit;
        logic tx_out;
        logic tx_parity;
        logic rx_parity_err;
    } state_t;
endpackage

//--- bench/wb_host_model.sv
`timescale 1ns/1ps
// host side of the register bus: one classic single cycle at a time
module wb_host_model (
    input wire logic clk_sys,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [3:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat,
    input wire logic [31:0] rdat,
    input wire logic ack
);
    // idle bus from time zero
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'h0;
        dat = 32'h0;
    end

    // request held until ack seen at an edge, released only then
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
                          output logic [31:0] q);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {24'h000000, d};
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        dat <= ~dat; // released data no longer shows the old value
    endtask
endmodule

//--- bench/test_uart_irq_ident_line_format.sv
`timescale 1ns/1ps
module test_uart_irq_ident_line_format;
    logic clk_sys, rstn, cyc, stb, we, ack, irq, tx_line, tx_parity, rx_parity_err;
    logic rx_data_available, tx_serial_in, rx_parity_in, rx_char_valid;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, q;
    logic [4:0] rx_count;
    logic [7:0] tx_char, rx_char;
    uart_ctrl_pkg::irq_events_t irq_events;
    uart_ctrl_pkg::line_cfg_t line_cfg;
    int num_errors = 0;
    int n_checks = 0;

    uart_ctrl u_dut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_events(irq_events), .rx_count(rx_count),
        .tx_serial_in(tx_serial_in), .tx_char(tx_char), .rx_char(rx_char),
        .rx_parity_in(rx_parity_in), .rx_char_valid(rx_char_valid), .tx_line(tx_line),
        .tx_parity(tx_parity), .rx_parity_err(rx_parity_err),
        .rx_data_available(rx_data_available), .irq(irq), .line_cfg(line_cfg));

    wb_host_model u_host (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat(wdat), .rdat(rdat), .ack(ack));

    // 125 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_host.access(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        u_host.access(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask

    // two edges, so registered outputs have landed before the next look
    task automatic settle();
        repeat (2) @(posedge clk_sys);
    endtask

    // expected parity bit, data masked to the word length
    function automatic logic par(input logic [7:0] lf, input logic [7:0] c);
        logic [7:0] m;
        m = c & (8'hFF >> (2'd3 - lf[1:0]));
        if (!lf[3]) return 1'b0;
        if (lf[5]) return ~lf[4];
        return lf[4] ? ^m : ~^m;
    endfunction

    task automatic test_reset();
        check(irq, 1'b0);
        check(tx_line, 1'b1);
        check(line_cfg.word_bits, 4'h5);
        check(line_cfg.stop_halves, uart_ctrl_pkg::STOP_ONE);
        rd(uart_ctrl_pkg::OFF_IDENT, 32'h00000001);
        rd(uart_ctrl_pkg::OFF_LINE_FORMAT, 32'h00000000);
        rd(4'h2, 32'h00000000);
        rd(uart_ctrl_pkg::OFF_FORMAT_STATUS, 32'h00002501);
        $display("test reset done");
    endtask

    task automatic test_trigger();
        logic [4:0] tbl [4];
        tbl = '{5'h01, 5'h04, 5'h08, 5'h0E};
        for (int i = 0; i < 4; i++)
        begin
            wr(uart_ctrl_pkg::OFF_FIFO_SETUP, {i[1:0], 6'h01});
            check(line_cfg.rx_threshold, tbl[i]);
            check(line_cfg.fifo_en, 1'b1);
            rd(uart_ctrl_pkg::OFF_IDENT, 32'h000000C1);
            @(posedge clk_sys);
            rx_count <= tbl[i] - 5'h01;
            settle();
            check(rx_data_available, 1'b0);
            rx_count <= tbl[i];
            settle();
            check(rx_data_available, 1'b1);
            rd(uart_ctrl_pkg::OFF_IDENT, 32'h000000C4);
            rx_count <= 5'h00;
        end
        wr(uart_ctrl_pkg::OFF_FIFO_SETUP, 8'h00);
        check(line_cfg.fifo_en, 1'b0);
        rd(uart_ctrl_pkg::OFF_IDENT, 32'h00000001);
        irq_events.rx_timeout <= 1'b1;
        @(posedge clk_sys);
        irq_events <= 4'h0;
        settle();
        check(irq, 1'b0);
        rd(uart_ctrl_pkg::OFF_IDENT, 32'h00000001);
        $display("test trigger done");
    endtask

    task automatic test_format();
        logic [7:0] lf, c;
        for (int i = 0; i < 64; i++)
        begin
            lf = {2'b00, i[5:0]};
            c = 8'(i * 37 + 90);
            wr(uart_ctrl_pkg::OFF_LINE_FORMAT, lf);
            rd(uart_ctrl_pkg::OFF_LINE_FORMAT, {24'h0, lf});
            check(line_cfg.word_bits, 4'h5 + lf[1:0]);
            check(line_cfg.stop_halves, !lf[2] ? 3'h2 : (lf[1:0] == 2'b00 ? 3'h3 : 3'h4));
            check({line_cfg.parity_forced, line_cfg.parity_even, line_cfg.parity_en},
                  lf[5:3]);
            tx_char <= c;
            rx_char <= c;
            rx_parity_in <= par(lf, c) ^ lf[2];
            rx_char_valid <= 1'b1;
            @(posedge clk_sys);
            rx_char_valid <= 1'b0;
            settle();
            check(tx_parity, par(lf, c));
            check(rx_parity_err, lf[3] & lf[2]);
        end
        $display("test format done");
    endtask

    task automatic test_break();
        tx_serial_in <= 1'b1;
        wr(uart_ctrl_pkg::OFF_LINE_FORMAT, 8'h40);
        check(line_cfg.break_on, 1'b1);
        settle();
        check(tx_line, 1'b0);
        wr(uart_ctrl_pkg::OFF_LINE_FORMAT, 8'h80);
        check(line_cfg.divisor_access, 1'b1);
        settle();
        check(tx_line, 1'b1);
        tx_serial_in <= 1'b0;
        settle();
        check(tx_line, 1'b0);
        wr(uart_ctrl_pkg::OFF_LINE_FORMAT, 8'h00);
        check(line_cfg.divisor_access, 1'b0);
        $display("test break done");
    endtask

    task automatic test_priority();
        wr(uart_ctrl_pkg::OFF_FIFO_SETUP, 8'h01);
        @(posedge clk_sys);
        irq_events.thr_empty <= 1'b1;
        @(posedge clk_sys);
        irq_events <= 4'h0;
        settle();
        check(irq, 1'b1);
        irq_events <= 4'hD;
        rx_count <= 5'h01;
        @(posedge clk_sys);
        irq_events <= 4'h0;
        settle();
        rd(uart_ctrl_pkg::OFF_IDENT, 32'h000000C2);
        rd(uart_ctrl_pkg::OFF_IDENT, 32'h000000C6);
        rd(uart_ctrl_pkg::OFF_IDENT, 32'h000000C4);
        rd(uart_ctrl_pkg::OFF_IDENT, 32'h000000CC);
        rd(uart_ctrl_pkg::OFF_IDENT, 32'h000000C0);
        rd(uart_ctrl_pkg::OFF_IDENT, 32'h000000C1);
        check(irq, 1'b0);
        $display("test priority done");
    endtask

    // cut a hang short, far beyond the expected run
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        num_errors++;
        results();
    end

    initial
    begin
        rstn <= 1'b0;
        irq_events <= 4'h0;
        rx_count <= 5'h00;
        tx_serial_in <= 1'b1;
        tx_char <= 8'h00;
        rx_char <= 8'h00;
        rx_parity_in <= 1'b0;
        rx_char_valid <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        test_reset();
        test_trigger();
        test_format();
        test_break();
        test_priority();
        results();
    end
endmodule
